// ---- design/bit_pkg.sv ----
// shared constants and state types of the basic interval timer
package bit_pkg;

	// ------------------------------------------------------------
	// register offsets (byte address)
	// ------------------------------------------------------------
	localparam logic [4:0] OFS_CURRENT_COUNT  = 5'h00;
	localparam logic [4:0] OFS_RELOAD_VALUE   = 5'h04;
	localparam logic [4:0] OFS_EVENT_FLAGS    = 5'h08;
	localparam logic [4:0] OFS_EVENT_IRQ_MASK = 5'h0C;
	localparam logic [4:0] OFS_TIMER_CONTROL  = 5'h10;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int EVT_LIMIT_BIT    = 0;
	localparam int CTL_ENABLE_BIT   = 0;
	localparam int CTL_COUNT_UP_BIT = 2;
	localparam int CTL_AUTO_RST_BIT = 3;
	localparam int CTL_SOFT_RST_BIT = 4;
	localparam int CTL_START_BIT    = 5;
	localparam int CTL_RELOAD_BIT   = 6;
	localparam int CTL_HALT_BIT     = 7;
	localparam int CTL_PRESCALE_LSB = 16;
	localparam int PRESCALE_W       = 16;

	// ------------------------------------------------------------
	// widths, masks and reset values
	// ------------------------------------------------------------
	localparam int          WIDTH_DEFAULT = 32;
	localparam logic [31:0] MASK_W16      = 32'h0000FFFF;
	localparam logic [31:0] MASK_W32      = 32'hFFFFFFFF;
	localparam logic [31:0] CTL_WR_MASK   = 32'hFFFF00AD;
	localparam logic [31:0] RESET_WORD    = 32'h00000000;
	localparam logic        RESET_BIT     = 1'b0;
	localparam logic [15:0] RESET_PRESC   = 16'h0000;

	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} bit_presc_state_type;

	typedef struct packed {
		logic [31:0] snap;
	} bit_snap_state_type;

	typedef struct packed {
		logic [31:0] count;
		logic [31:0] preload;
		logic [31:0] ctrl;
		logic        flag;
		logic        irq_en;
		logic        soft_rst;
		logic        irq;
		logic        sleep_ack;
		logic        asleep;
		logic [31:0] rdata;
		logic        rvalid;
	} bit_core_state_type;

endpackage : bit_pkg

// ---- design/bit_prescaler.sv ----
// prescaler that turns the core clock into one-cycle count enables
`timescale 1ns/1ns
module bit_prescaler
(
	// clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          rst,
	// control
	input  wire logic                          run,
	input  wire logic [bit_pkg::PRESCALE_W-1:0] divide,
	// enable out
	output logic                               tick
);

	bit_pkg::bit_presc_state_type s_reg;
	bit_pkg::bit_presc_state_type s_next;

	// a divide of n gives one tick every n+1 clocks
	always_comb
	begin
		s_next      = s_reg;
		s_next.tick = 1'b0;
		if (!run)
		begin
			// restart the phase so the first step after start is a full period
			s_next.cnt = bit_pkg::RESET_PRESC;
		end
		else if (s_reg.cnt >= divide)
		begin
			s_next.cnt  = bit_pkg::RESET_PRESC;
			s_next.tick = 1'b1; // see [R3]
		end
		else
		begin
			s_next.cnt = s_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;

endmodule : bit_prescaler

// ---- design/bit_count_snap.sv ----
// holding register that freezes the count for byte-wise reads
`timescale 1ns/1ns
module bit_count_snap
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// capture
	input  wire logic        capture,
	input  wire logic [31:0] value,
	// frozen copy
	output logic      [31:0] snap
);

	bit_pkg::bit_snap_state_type s_reg;
	bit_pkg::bit_snap_state_type s_next;

	always_comb
	begin
		s_next = s_reg;
		if (capture)
		begin
			s_next.snap = value; // see [R16]
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			s_reg <= '0;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign snap = s_reg.snap;

endmodule : bit_count_snap

// ---- design/bit_timer.sv ----
// basic interval timer: counter, register file, reset and sleep handshake
//
// Operation
// [R1] width parameter selects a 16 or 32 bit count and preload
// [R2] all logic runs on one clock, divided by a prescaler
// [R3] control prescale field sets the time of each count step
// [R4] system reset returns every register and state to defaults
// [R5] soft reset control bit makes an internal reset of the block
// [R6] timer reset is system reset ORed with soft reset
// [R7] limit sets event flag; interrupt output only while enabled
// [R8] low-power request acknowledged only while the block is inactive
// [R9] asleep when disabled, not started, or halted
// [R10] block counts as active whenever start is set
// [R11] control bit selects counting up or down
// [R12] one-shot: stop at limit, event held as a level
// [R13] continuous: reload preload at limit, event as one-cycle pulse
// [R14] software reloads, halts or starts the counter via control
// [R15] count, preload, status, enable, control at offsets 00h..10h
// [R16] count reads buffered for byte reads; 16-bit upper bits zero
// [R17] event flag cleared by writing one to it
// [R18] limit is all ones counting up, zero counting down
// [R19] software writes the counter only while halted or stopped; here count writes are also accepted while running
`timescale 1ns/1ns
module bit_timer
#(
	parameter int WIDTH = bit_pkg::WIDTH_DEFAULT
)
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst,
	// host register port
	input  wire logic [4:0]  host_addr,
	input  wire logic        host_wr,
	input  wire logic        host_rd,
	input  wire logic [3:0]  host_be,
	input  wire logic [31:0] host_wdata,
	output logic      [31:0] host_rdata,
	output logic             host_rvalid,
	// interrupt
	output logic             timer_irq,
	// power_clock_reset_unit handshake
	input  wire logic        sleep_req,
	output logic             sleep_ack,
	output logic             asleep
);

	// ------------------------------------------------------------
	// width selection
	// ------------------------------------------------------------
	localparam logic [31:0] WMASK = (WIDTH == 16) ? bit_pkg::MASK_W16
	                                              : bit_pkg::MASK_W32; // see [R1]

	bit_pkg::bit_core_state_type s_reg;
	bit_pkg::bit_core_state_type s_next;

	logic        timer_rst;
	logic        run;
	logic        tick;
	logic        count_up;
	logic [31:0] limit;
	logic [31:0] stepped;
	logic [31:0] snap;
	logic        cap;
	logic        sel_count;
	logic        sel_preload;
	logic        sel_flags;
	logic        sel_mask;
	logic        sel_ctrl;
	logic        wr_reload;
	logic [31:0] ctl_wr;

	// ------------------------------------------------------------
	// reset and run conditions
	// ------------------------------------------------------------
	assign timer_rst = rst | s_reg.soft_rst; // see [R4] see [R6]
	assign run       = s_reg.ctrl[bit_pkg::CTL_ENABLE_BIT]
	                 & s_reg.ctrl[bit_pkg::CTL_START_BIT]
	                 & ~s_reg.ctrl[bit_pkg::CTL_HALT_BIT];
	assign count_up  = s_reg.ctrl[bit_pkg::CTL_COUNT_UP_BIT];
	assign limit     = count_up ? WMASK : 32'h00000000; // see [R18]
	assign stepped   = (count_up ? s_reg.count + 32'h00000001
	                             : s_reg.count - 32'h00000001) & WMASK; // see [R11]

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign sel_count   = host_addr == bit_pkg::OFS_CURRENT_COUNT; // see [R15]
	assign sel_preload = host_addr == bit_pkg::OFS_RELOAD_VALUE;
	assign sel_flags   = host_addr == bit_pkg::OFS_EVENT_FLAGS;
	assign sel_mask    = host_addr == bit_pkg::OFS_EVENT_IRQ_MASK;
	assign sel_ctrl    = host_addr == bit_pkg::OFS_TIMER_CONTROL;

	// the low byte read freezes the whole count for the following bytes
	assign cap       = host_rd & sel_count & host_be[0]; // see [R16]
	assign ctl_wr    = merge(s_reg.ctrl, host_wdata, host_be);
	assign wr_reload = host_wr & sel_ctrl & host_be[0]
	                 & host_wdata[bit_pkg::CTL_RELOAD_BIT];

	// byte-lane merge of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] wd,
	                                      input logic [3:0]  be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
			begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// ------------------------------------------------------------
	// prescaler and read buffer
	// ------------------------------------------------------------
	bit_prescaler u_prescaler
	(
		.core_clk (core_clk),
		.rst      (timer_rst),
		.run      (run),
		.divide   (s_reg.ctrl[bit_pkg::CTL_PRESCALE_LSB +: bit_pkg::PRESCALE_W]),
		.tick     (tick)
	); // see [R2] see [R3]

	bit_count_snap u_snap
	(
		.core_clk (core_clk),
		.rst      (timer_rst),
		.capture  (cap),
		.value    (s_reg.count & WMASK),
		.snap     (snap)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		logic hit;
		logic clr;
		hit = 1'b0;
		clr = 1'b0;
		s_next          = s_reg;
		s_next.rvalid   = 1'b0;
		s_next.soft_rst = 1'b0;

		// counting; writes to the count while running are not guarded
		if (run && tick)
		begin
			hit = (stepped == limit);
			if (hit && s_reg.ctrl[bit_pkg::CTL_AUTO_RST_BIT])
			begin
				s_next.count = s_reg.preload & WMASK; // see [R13]
			end
			else if (hit)
			begin
				s_next.count                        = stepped;
				s_next.ctrl[bit_pkg::CTL_START_BIT] = 1'b0; // see [R12]
			end
			else
			begin
				s_next.count = stepped;
			end
		end

		// register writes
		if (host_wr)
		begin
			if (sel_count)
			begin
				s_next.count = merge(s_reg.count, host_wdata, host_be) & WMASK; // see [R19]
			end
			if (sel_preload)
			begin
				s_next.preload = merge(s_reg.preload, host_wdata, host_be) & WMASK; // see [R16]
			end
			if (sel_flags && host_be[0])
			begin
				clr = host_wdata[bit_pkg::EVT_LIMIT_BIT]; // see [R17]
			end
			if (sel_mask && host_be[0])
			begin
				s_next.irq_en = host_wdata[bit_pkg::EVT_LIMIT_BIT];
			end
			if (sel_ctrl)
			begin
				s_next.ctrl = ctl_wr & bit_pkg::CTL_WR_MASK; // see [R14]
				if (host_be[0] && host_wdata[bit_pkg::CTL_SOFT_RST_BIT])
				begin
					s_next.soft_rst = 1'b1; // see [R5]
				end
			end
		end
		if (wr_reload)
		begin
			s_next.count = s_reg.preload & WMASK; // see [R14]
		end

		// continuous mode shows a pulse, one-shot a held level; set beats clear
		if (s_reg.ctrl[bit_pkg::CTL_AUTO_RST_BIT])
		begin
			s_next.flag = hit; // see [R13]
		end
		else
		begin
			s_next.flag = hit | (s_reg.flag & ~clr); // see [R12] see [R17]
		end
		s_next.irq = s_next.flag & s_next.irq_en; // see [R7]

		// low-power handshake
		s_next.sleep_ack = sleep_req & ~s_next.ctrl[bit_pkg::CTL_START_BIT]; // see [R8] see [R10]
		s_next.asleep    = ~s_next.ctrl[bit_pkg::CTL_ENABLE_BIT]
		                 | ~s_next.ctrl[bit_pkg::CTL_START_BIT]
		                 | s_next.ctrl[bit_pkg::CTL_HALT_BIT]; // see [R9]

		// register reads
		if (host_rd)
		begin
			s_next.rvalid = 1'b1;
			s_next.rdata  = bit_pkg::RESET_WORD;
			if (sel_count)
			begin
				s_next.rdata = cap ? (s_reg.count & WMASK) : snap; // see [R16]
			end
			else if (sel_preload)
			begin
				s_next.rdata = s_reg.preload & WMASK;
			end
			else if (sel_flags)
			begin
				s_next.rdata[bit_pkg::EVT_LIMIT_BIT] = s_reg.flag;
			end
			else if (sel_mask)
			begin
				s_next.rdata[bit_pkg::EVT_LIMIT_BIT] = s_reg.irq_en;
			end
			else if (sel_ctrl)
			begin
				s_next.rdata = s_reg.ctrl;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (timer_rst)
		begin
			s_reg        <= '0; // see [R4] see [R5]
			s_reg.asleep <= 1'b1;
		end
		else
		begin
			s_reg <= s_next;
		end
	end

	assign host_rdata  = s_reg.rdata;
	assign host_rvalid = s_reg.rvalid;
	assign timer_irq   = s_reg.irq;
	assign sleep_ack   = s_reg.sleep_ack;
	assign asleep      = s_reg.asleep;

endmodule : bit_timer

// ---- bench/bit_timer_asserts.sv ----
// port-level assertions for the interval timer
`timescale 1ns/1ns
module bit_timer_asserts
(
	// clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// host port
	input wire logic [4:0]  host_addr,
	input wire logic        host_wr,
	input wire logic        host_rd,
	input wire logic [3:0]  host_be,
	input wire logic [31:0] host_wdata,
	input wire logic [31:0] host_rdata,
	input wire logic        host_rvalid,
	// event and power
	input wire logic        timer_irq,
	input wire logic        sleep_req,
	input wire logic        sleep_ack,
	input wire logic        asleep
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (rst);
	logic ctl_wr;
	assign ctl_wr = host_wr && host_addr == 5'h10 && host_be[0];

	a_read_answer: assert property (host_rd |=> host_rvalid)
		else $error("read not answered");
	a_unmapped_zero: assert property (host_rd && host_addr == 5'h14 |=> host_rdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (host_wr && host_addr == 5'h0C && host_be[0]
		&& !host_wdata[0] |=> !timer_irq)
		else $error("irq while masked");
	a_ack_needs_req: assert property (!sleep_req |=> !sleep_ack)
		else $error("ack without request");
	a_stop_sleeps: assert property (ctl_wr && (!host_wdata[0] || host_wdata[7]) |=> asleep)
		else $error("awake while stopped");
	a_run_awake: assert property (ctl_wr && (host_wdata[7:0] & 8'hB1) == 8'h21 |=> !asleep)
		else $error("asleep while started");
	// the request flop sets on the edge that takes the write and resets the block at the next one
	a_soft_reset: assert property (ctl_wr && host_wdata[4] |-> ##3 asleep && !timer_irq)
		else $error("soft reset missing");
	a_sys_reset: assert property (disable iff (1'b0)
		rst |=> asleep && !timer_irq && !sleep_ack && !host_rvalid)
		else $error("reset state wrong");
endmodule : bit_timer_asserts

// ---- bench/bit_timer_test.sv ----
// self-checking bench of the interval timer
`timescale 1ns/1ns
module bit_timer_test;
	logic        core_clk, rst, host_wr, host_rd, sleep_req;
	logic        host_rvalid, timer_irq, sleep_ack, asleep;
	logic [4:0]  host_addr;
	logic [3:0]  host_be;
	logic [31:0] host_wdata, host_rdata, d, p, seed;
	int          err_count, n_compared, i;

	bit_timer #(.WIDTH(32)) i_bit_timer (.core_clk(core_clk), .rst(rst),
		.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_be(host_be),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.timer_irq(timer_irq), .sleep_req(sleep_req), .sleep_ack(sleep_ack), .asleep(asleep));

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	// limit the counter stops at or reloads on
	function logic [31:0] lim(input logic up);
		return up ? 32'hFFFFFFFF : 32'h00000000;
	endfunction : lim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [4:0] a, input logic [31:0] v);
		@(negedge core_clk);
		host_addr = a;
		host_wdata = v;
		host_be = 4'hF;
		host_wr = 1'b1;
		@(negedge core_clk);
		host_wr = 1'b0;
	endtask : wr

	task rd(input logic [4:0] a, input logic [3:0] b);
		@(negedge core_clk);
		host_addr = a;
		host_be = b;
		host_rd = 1'b1;
		@(negedge core_clk);
		host_rd = 1'b0;
		d = host_rdata;
	endtask : rd

	task wait_irq();
		for (i = 0; i < 100 && timer_irq !== 1'b1; i++)
			@(negedge core_clk);
	endtask : wait_irq

	task summarize();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// whole run is under two hundred cycles
	initial
	begin
		#100000;
		err_count++;
		summarize();
	end

	// ----------------
	// main sequence
	// ----------------
	initial
	begin
		{host_wr, host_rd, sleep_req, host_addr, host_be, host_wdata} = '0;
		seed = 32'h190FB753;
		rst = 1'b1;
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		for (int k = 0; k < 6; k++)
		begin
			rd(5'(k * 4), 4'hF);
			chk(d, 32'h0);
		end
		for (int k = 0; k < 4; k++)
		begin
			p = rnd();
			wr(5'h04, p);
			wr(5'h0C, p);
			rd(5'h04, 4'hF);
			chk(d, p);
			rd(5'h0C, 4'hF);
			chk(d, {31'h0, p[0]});
		end
		$display("test registers done");
		wr(5'h0C, 32'h1);
		wr(5'h00, lim(1'b1) - 32'h1 - (rnd() & 32'hF));
		sleep_req = 1'b1;
		wr(5'h10, 32'h25);
		@(negedge core_clk);
		chk(sleep_ack, 1'b0);
		wait_irq();
		chk(timer_irq, 1'b1);
		rd(5'h10, 4'hF);
		chk(d, 32'h05);
		rd(5'h00, 4'hF);
		chk(d, lim(1'b1));
		rd(5'h08, 4'hF);
		chk(d, 32'h1);
		chk({asleep, sleep_ack}, 2'b11);
		wr(5'h08, 32'h1);
		chk(timer_irq, 1'b0);
		$display("test one-shot done");
		p = (rnd() & 32'h7) + 32'h4;
		wr(5'h04, p);
		wr(5'h00, 32'h2);
		wr(5'h10, 32'h00030029);
		wait_irq();
		chk(timer_irq, 1'b1);
		@(negedge core_clk);
		chk({timer_irq, asleep, sleep_ack}, 3'b000);
		wr(5'h10, 32'h000300E9);
		rd(5'h00, 4'hF);
		chk(d, p);
		rd(5'h00, 4'hF);
		chk(d, p);
		chk(asleep, 1'b1);
		wr(5'h10, 32'h00000029);
		rd(5'h00, 4'h1);
		p = d;
		rd(5'h00, 4'h2);
		chk(d, p);
		$display("test continuous done");
		wr(5'h10, 32'h10);
		// a request in the cycle the internal reset fires would be lost
		@(negedge core_clk);
		rd(5'h04, 4'hF);
		chk(d, 32'h0);
		rd(5'h0C, 4'hF);
		chk(d, 32'h0);
		chk(sleep_ack, 1'b1);
		$display("test soft reset done");
		summarize();
	end
endmodule : bit_timer_test

bind bit_timer bit_timer_asserts i_bit_timer_asserts (.core_clk(core_clk), .rst(rst),
	.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_be(host_be),
	.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
	.timer_irq(timer_irq), .sleep_req(sleep_req), .sleep_ack(sleep_ack), .asleep(asleep));
